// >>> common/adc_pkg.sv
/*
 * package for the converter output control block: code constants,
 * pipeline and timing figures, sample carrier struct.
 * assumes a single 125 MHz clock domain and synchronous reset.
 */
package adc_pkg;

    // ***********************************************************
    // widths and codes
    // ***********************************************************
    localparam int          SAMPLE_W     = 14;
    localparam logic [13:0] CODE_POS_FS  = 14'h3FFF;
    localparam logic [13:0] CODE_ZERO    = 14'h2000;
    localparam logic [13:0] CODE_NEG_FS  = 14'h0000;
    localparam int          MSB_POS      = 13;

    // ***********************************************************
    // pipeline and clock figures
    // ***********************************************************
    localparam int          PIPE_LAT     = 8;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          CLK_MHZ      = 125;
    localparam int          SAMPLE_MAX_MHZ = 40;
    // least clk cycles per sample at the highest sample rate
    localparam int          SAMPLE_DIV   =
        (CLK_MHZ + SAMPLE_MAX_MHZ - 1) / SAMPLE_MAX_MHZ;

    // ***********************************************************
    // carrier
    // ***********************************************************
    typedef struct packed {
        logic        over_pos;
        logic        over_neg;
        logic [13:0] code;
    } adc_smp_s;

endpackage

// >>> design/adc_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and synchronous active-high reset.
 */
module adc_fifo
    import adc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    wire              do_wr;
    wire              do_rd;

    assign in_ready  = (count_ff != DEPTH[AW:0]);
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (do_wr) wr_ptr_ff <= inc(wr_ptr_ff);
            if (do_rd) rd_ptr_ff <= inc(rd_ptr_ff);
            count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// >>> design/adc_out_ctrl.sv
/*
 * digital output control of a 14-bit pipelined converter: sample
 * pipeline, output coding, saturation, output enable, power-down.
 * assumes raw samples come from converter logic on clk, one per
 * sample_tick; format, enable and power-down pins are asynchronous.
 */
// Functional notes
// - format pin high gives two's complement, low gives offset binary.
// - two's complement equals offset binary with the msb inverted.
// - offset binary: +fs-1lsb all ones, zero 0x2000, -fs all zeros.
// - over-range gives the full-scale code of the selected format.
// - output enable low drives the data pins, high releases them.
// - power-down halts conversion but keeps the reference alive.
// - power-down flushes the pipeline; valid returns after latency.
// - one sample per sample clock, up to 40 MHz.
// - each sample advances one stage per sample clock.
module adc_out_ctrl
    import adc_pkg::*;
#(
    parameter int LATENCY = PIPE_LAT,
    parameter int DEPTH   = FIFO_DEPTH,
    parameter int DIV     = SAMPLE_DIV
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // raw samples from the converter core
    input  wire logic                smp_valid,
    output logic                     smp_ready,
    input  wire adc_smp_s            smp_in,
    // pins
    input  wire logic                twos_complement_select,
    input  wire logic                out_enable_n,
    input  wire logic                power_down,
    // parallel data outputs
    output logic [SAMPLE_W-1:0]      data_o,
    output logic [SAMPLE_W-1:0]      data_oe,
    output logic                     data_valid,
    // analog block control
    output logic                     core_enable,
    output logic                     ref_enable
);
    // ***********************************************************
    // pin synchronisers
    // ***********************************************************
    // reset leaves the pins released and the core powered down
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    wire        fmt_twos;
    wire        pwr_dn_s;
    wire        oe_n_s;
    wire        flush;

    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_ff <= 3'h6;
            sync2_ff <= 3'h6;
        end else begin
            sync1_ff <= {out_enable_n, power_down, twos_complement_select};
            sync2_ff <= sync1_ff;
        end
    end

    assign fmt_twos = sync2_ff[0];
    assign pwr_dn_s = sync2_ff[1];
    assign oe_n_s   = sync2_ff[2];
    assign flush    = reset || pwr_dn_s;

    // ***********************************************************
    // sample tick divider
    // ***********************************************************
    // an integer divide of clk cannot hit 40 MHz exactly,
    // so the tick takes the nearest rate at or below it
    localparam int DW = $clog2(DIV + 1);

    logic [DW-1:0] div_ff;
    wire  [DW-1:0] nxt_div;
    wire           div_wrap;
    wire           tick;

    assign div_wrap = (div_ff == DW'(DIV - 1));
    assign tick     = div_wrap && !pwr_dn_s;
    assign nxt_div  = (flush || tick) ? '0 : div_ff + 1'b1;

    always_ff @(posedge clk) begin
        div_ff <= nxt_div;
    end

    // ***********************************************************
    // input fifo
    // ***********************************************************
    // fifo and fill count restart together on power-down
    adc_smp_s fifo_q;
    logic     fifo_v;
    wire      fifo_pop;
    wire      fifo_ok;

    assign fifo_pop = tick;

    adc_fifo #(
        .WIDTH ($bits(adc_smp_s)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (flush),
        .in_valid  (smp_valid),
        .in_ready  (fifo_ok),
        .in_data   (smp_in),
        .out_valid (fifo_v),
        .out_ready (fifo_pop),
        .out_data  (fifo_q)
    );

    assign smp_ready = fifo_ok && !pwr_dn_s;

    // ***********************************************************
    // coding
    // ***********************************************************
    // saturation first, then the format's msb flip
    function automatic logic [13:0] encode(input adc_smp_s s,
                                           input logic twos);
        logic [13:0] ob;
        ob = s.over_pos ? CODE_POS_FS :
             s.over_neg ? CODE_NEG_FS : s.code;
        encode = ob;
        if (twos) begin
            encode[MSB_POS] = ~ob[MSB_POS];
        end
    endfunction

    // ***********************************************************
    // pipeline
    // ***********************************************************
    // an empty fifo on a tick feeds bipolar zero
    localparam adc_smp_s IDLE_SMP = '{1'b0, 1'b0, CODE_ZERO};
    localparam int       LW       = $clog2(LATENCY + 1);

    adc_smp_s      pipe_ff [LATENCY];
    adc_smp_s      stage_in;

    assign stage_in = fifo_v ? fifo_q : IDLE_SMP;

    always_ff @(posedge clk) begin
        if (flush) begin
            for (int i = 0; i < LATENCY; i++) begin
                pipe_ff[i] <= IDLE_SMP;
            end
        end else if (tick) begin
            pipe_ff[0] <= stage_in;
            for (int i = 1; i < LATENCY; i++) begin
                pipe_ff[i] <= pipe_ff[i-1];
            end
        end
    end

    // ***********************************************************
    // fill counter
    // ***********************************************************
    // counts ticks since restart, stops at the latency
    logic [LW-1:0] fill_ff;
    wire  [LW-1:0] nxt_fill;
    wire           pipe_full;

    assign pipe_full = (fill_ff == LW'(LATENCY));
    assign nxt_fill  = pipe_full ? fill_ff : fill_ff + 1'b1;

    always_ff @(posedge clk) begin
        if (flush) begin
            fill_ff <= '0;
        end else if (tick) begin
            fill_ff <= nxt_fill;
        end
    end

    // ***********************************************************
    // output word selection
    // ***********************************************************
    wire [13:0] nxt_data;
    wire        nxt_valid;

    assign nxt_data  = encode(pipe_ff[LATENCY-1], fmt_twos);
    assign nxt_valid = pipe_full;

    // ***********************************************************
    // output register
    // ***********************************************************
    // holds between ticks, one word per sample
    logic [13:0] data_ff;
    logic        valid_ff;

    always_ff @(posedge clk) begin
        if (flush) begin
            data_ff  <= CODE_NEG_FS;
            valid_ff <= 1'b0;
        end else if (tick) begin
            data_ff  <= nxt_data;
            valid_ff <= nxt_valid;
        end
    end

    // ***********************************************************
    // output pins
    // ***********************************************************
    // pins float whenever the enable pin is high
    assign data_o     = data_ff;
    assign data_oe    = {SAMPLE_W{!oe_n_s}};
    assign data_valid = valid_ff;

    // ***********************************************************
    // power control
    // ***********************************************************
    // the reference stays up for a fast restart
    assign core_enable = !pwr_dn_s;
    assign ref_enable  = 1'b1;
endmodule

// >>> tb/adc_out_ctrl_asserts.sv
/* checker for the output control ports.
   assumes one clk domain, sync reset. */
module adc_out_asserts
    import adc_pkg::*;
#(
    parameter int LATENCY = 8,
    parameter int DIV     = 4
) (
    // watched ports
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                smp_valid,
    input wire logic                smp_ready,
    input wire logic                out_enable_n,
    input wire logic                power_down,
    input wire logic [SAMPLE_W-1:0] data_o,
    input wire logic [SAMPLE_W-1:0] data_oe,
    input wire logic                data_valid,
    input wire logic                core_enable,
    input wire logic                ref_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // run-time counter
    // ********
    localparam int VMAX = (LATENCY + 2) * DIV;
    logic [7:0] on_cnt_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    always_ff @(posedge clk) begin
        if (reset || !core_enable)
            on_cnt_ff <= 8'h00;
        else if (on_cnt_ff != 8'(VMAX))
            on_cnt_ff <= on_cnt_ff + 8'h01;
    end
    // ********
    // properties
    // ********
    ref_on_a: assert property (ref_enable)
        else $error("reference disabled");
    down_core_a: assert property (power_down[*4] |-> !core_enable)
        else $error("core on in power-down");
    down_refuse_a: assert property (power_down[*3] |-> !smp_ready)
        else $error("sample taken in power-down");
    oe_on_a: assert property ((!out_enable_n)[*4] |-> &data_oe)
        else $error("outputs not driven");
    oe_drive_a: assert property (out_enable_n[*4]
        |-> data_oe == {SAMPLE_W{!out_enable_n}})
        else $error("output enable wrong");
    word_hold_a: assert property (@(posedge clk)
        disable iff (reset || power_down)
        $changed(data_o) |=> $stable(data_o)[*3])
        else $error("word changed early");
    valid_early_a: assert property (data_valid && core_enable
        |-> on_cnt_ff >= 8'((LATENCY - 1) * DIV))
        else $error("valid before latency");
    valid_late_a: assert property (
        on_cnt_ff == 8'(VMAX) |-> data_valid)
        else $error("valid missing");
    valid_fall_a: assert property ($fell(data_valid) |-> power_down)
        else $error("valid lost without power-down");
    cover property (smp_valid && !smp_ready && !power_down);
    cover property ($rose(data_valid));
    cover property ($fell(core_enable));
endmodule

bind adc_out_ctrl adc_out_asserts #(.LATENCY(LATENCY), .DIV(DIV))
    adc_out_asserts_i (.clk, .reset, .smp_valid, .smp_ready,
    .out_enable_n, .power_down, .data_o, .data_oe, .data_valid,
    .core_enable, .ref_enable);

// >>> tb/adc_capture.sv
/* downstream capture model: records each new valid word.
   assumes pull-ups on the data lines when released. */
module adc_capture
    import adc_pkg::*;
(
    // clock
    input wire logic                clk,
    // data pins
    input wire logic [SAMPLE_W-1:0] data_o,
    input wire logic [SAMPLE_W-1:0] data_oe,
    input wire logic                data_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // bus and capture
    // ********
    logic [SAMPLE_W-1:0] bus;
    logic [SAMPLE_W-1:0] last;
    logic [SAMPLE_W-1:0] got[$];
    logic                was = 1'b0;
    assign bus = data_o | ~data_oe;
    always @(posedge clk) begin
        if (data_valid && (!was || bus !== last))
            got.push_back(bus);
        last = bus;
        was = data_valid;
    end
endmodule

// >>> tb/adc_digital_output_control_tb.sv
/* random and corner stream test of the output control.
   assumes adc_capture and the bound checker. */
module adc_digital_output_control_tb
    import adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // signals and instances
    // ********
    logic                clk, reset, smp_valid, smp_ready, fmt, oe_n, pwr_dn;
    adc_smp_s            smp_in;
    logic [SAMPLE_W-1:0] data_o, data_oe;
    logic                data_valid, core_enable, ref_enable;
    int                  mismatches, checks_done, seed;
    adc_out_ctrl #(.LATENCY(2)) adc_out_ctrl_i (.clk, .reset, .smp_valid,
        .smp_ready, .smp_in, .twos_complement_select(fmt),
        .out_enable_n(oe_n), .power_down(pwr_dn), .data_o, .data_oe,
        .data_valid, .core_enable, .ref_enable);
    adc_capture adc_capture_i (.clk, .data_o, .data_oe, .data_valid);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ********
    // helpers
    // ********
    function automatic logic [13:0] enc(adc_smp_s s, logic f);
        logic [13:0] c;
        c = s.over_pos ? CODE_POS_FS : s.over_neg ? CODE_NEG_FS : s.code;
        return {c[MSB_POS] ^ f, c[MSB_POS-1:0]};
    endfunction
    task automatic cmp(string what, logic [13:0] exp, logic [13:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic run(logic f);
        adc_smp_s s, prv, q[$];
        adc_smp_s cor[5] = '{'{1, 0, 14'h0155}, '{0, 1, 14'h3FFF},
            '{1, 1, 14'h0000}, '{0, 0, 14'h0000}, '{0, 0, 14'h3FFF}};
        logic [13:0] z;
        logic [13:0] cap[$];
        int k;
        z = f ? 14'h0000 : CODE_ZERO;
        pwr_dn = 1'b1;
        fmt = f;
        repeat (6) @(negedge clk);
        cmp("ready in power-down", 14'h0, {13'h0, smp_ready});
        cmp("valid in power-down", 14'h0, {13'h0, data_valid});
        cmp("word in power-down", CODE_NEG_FS, data_o);
        cmp("core in power-down", 14'h0, {13'h0, core_enable});
        cmp("reference kept", 14'h1, {13'h0, ref_enable});
        oe_n = 1'b1;
        repeat (4) @(negedge clk);
        cmp("released bus", CODE_POS_FS, adc_capture_i.bus);
        adc_capture_i.got.delete();
        oe_n = 1'b0;
        pwr_dn = 1'b0;
        repeat (4) @(negedge clk);
        cmp("driven enable", 14'h3FFF, data_oe);
        cmp("core awake", 14'h1, {13'h0, core_enable});
        for (int i = 0; i < 24; i++) begin
            if (i < 5)
                s = cor[i];
            else
                do s = 16'($random(seed));
                while (enc(s, f) == enc(prv, f) || enc(s, f) == z);
            smp_in = s;
            smp_valid = 1'b1;
            for (int j = 0; j < 64 && smp_ready !== 1'b1; j++)
                @(negedge clk);
            @(negedge clk);
            q.push_back(s);
            prv = s;
        end
        smp_valid = 1'b0;
        repeat (80) @(negedge clk);
        cmp("valid after stream", 14'h1, {13'h0, data_valid});
        cap = adc_capture_i.got;
        k = 0;
        while (k < cap.size() && cap[k] == z)
            k++;
        foreach (q[i])
            cmp("word", enc(q[i], f), cap[k+i]);
    endtask
    // ********
    // sequence
    // ********
    initial begin
        seed = 32'he343;
        reset = 1'b1;
        smp_valid = 1'b0;
        smp_in = '0;
        fmt = 1'b0;
        oe_n = 1'b0;
        pwr_dn = 1'b0;
        repeat (16) @(negedge clk);
        reset = 1'b0;
        run(1'b0);
        run(1'b1);
        summarize();
    end
    initial begin
        #160000;
        mismatches++;
        summarize();
    end
endmodule
